// ===== include/dfps_pkg.sv
package dfps_pkg;
  // register indices on the byte-wide register port
  localparam logic [1:0] DFPS_IDX_CLK_EN = 2'h0;
  localparam logic [1:0] DFPS_IDX_STATUS = 2'h1;
  localparam logic [1:0] DFPS_IDX_EVENT = 2'h2;
  localparam logic [1:0] DFPS_IDX_LOL_CNT = 2'h3;

  // enable byte field positions
  localparam int DFPS_B_D2_BANK6 = 7;
  localparam int DFPS_B_D2_BANK5 = 6;
  localparam int DFPS_B_D2_BANK4 = 5;
  localparam int DFPS_B_D1_BANK2 = 4;
  localparam int DFPS_B_D1_BANK1 = 3;
  localparam int DFPS_B_D1_BANK0 = 2;
  localparam int DFPS_B_D0_BANK1 = 1;
  localparam int DFPS_B_D0_BANK0 = 0;

  // event field positions, and the status lock bit
  localparam int DFPS_E_RAIL_HIGH = 3;
  localparam int DFPS_E_RAIL_LOW = 2;
  localparam int DFPS_E_LOL_LMT = 1;
  localparam int DFPS_E_LOL = 0;
  localparam int DFPS_S_LOCK = 0;

  localparam logic [7:0] DFPS_CLK_EN_RST = 8'hff;
  localparam logic [3:0] DFPS_EVT_RST = 4'h0;
  localparam logic [3:0] DFPS_CNT_RST = 4'h0;
  localparam logic [3:0] DFPS_CNT_MAX = 4'hf;
  localparam logic [2:0] DFPS_AUTO_SRC = 3'h2;
  localparam int DFPS_AUTO_BANKS = 3;

  // register port request
  typedef struct packed {
    logic wr;
    logic [1:0] idx;
    logic [7:0] wdata;
  } dfps_req_t;

  // lock detector reports
  typedef struct packed {
    logic locked;
    logic rail_high;
    logic rail_low;
  } dfps_det_t;

  // per-bank automatic fanout state for banks 4..6
  typedef struct packed {
    logic auto_mode;
    logic [2:0] src;
    logic mux_sel;
  } dfps_bank_t;
endpackage

// ===== core/dfps_sticky.sv
`timescale 1ns/1ns
// one write-one-to-clear flag; set wins over clear, clear may be blocked
module dfps_sticky
  import dfps_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic set,
  input wire logic clr,
  input wire logic hold,
  output logic flag_q
);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr && !hold) begin
      flag_q <= 1'b0;
    end
  end
endmodule

// ===== core/dfps_lol_counter.sv
`timescale 1ns/1ns
// saturating loss-of-lock counter with software load
module dfps_lol_counter
  import dfps_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic inc,
  input wire logic load,
  input wire logic [3:0] load_val,
  output logic [3:0] count_q
);
  // a load beats a coincident increment so writing zero really clears
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_q <= DFPS_CNT_RST;
    end else if (load) begin
      count_q <= load_val;
    end else if (inc && count_q != DFPS_CNT_MAX) begin
      count_q <= count_q + 4'h1;
    end
  end
endmodule

// ===== core/dfps_top.sv
`timescale 1ns/1ns
module dfps_top
  import dfps_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input dfps_pkg::dfps_req_t req,
  output logic [7:0] rdata,
  input dfps_pkg::dfps_det_t det,
  input wire logic [3:0] lol_cnt_thresh,
  input dfps_pkg::dfps_bank_t [2:0] bank_auto,
  input wire logic [2:0] div0_clk,
  output logic [7:0] bank_clk_gated,
  output logic [7:0] clk_en
);
  import dfps_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // enable register
  logic [7:0] en_q;
  logic [7:0] en_d;
  logic [2:0] auto_take;
  logic wr_en;
  assign wr_en = req.wr && req.idx == DFPS_IDX_CLK_EN;

  // bank_auto[k] serves bank 4+k, whose divider-2 bit is DFPS_B_D2_BANK4+k
  genvar k;
  generate
    for (k = 0; k < DFPS_AUTO_BANKS; k++) begin : g_auto
      assign auto_take[k] = bank_auto[k].auto_mode &&
                            bank_auto[k].src == DFPS_AUTO_SRC;
    end
  endgenerate

  always_comb begin
    en_d = en_q;
    if (wr_en) begin
      en_d = req.wdata;
    end
    for (int i = 0; i < DFPS_AUTO_BANKS; i++) begin
      if (auto_take[i]) begin
        en_d[DFPS_B_D2_BANK4 + i] = bank_auto[i].mux_sel;
      end
    end
  end

  // every enable comes out of reset passing its clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      en_q <= DFPS_CLK_EN_RST;
    end else begin
      en_q <= en_d;
    end
  end
  assign clk_en = en_q;

  ////////////////////////////////////////////////////////////////////////
  // clock gating onto the bank muxes; a plain and gate, so the
  // enable should only move while the divider clock is low
  always_comb begin
    bank_clk_gated[DFPS_B_D2_BANK6] = div0_clk[2] & en_q[DFPS_B_D2_BANK6];
    bank_clk_gated[DFPS_B_D2_BANK5] = div0_clk[2] & en_q[DFPS_B_D2_BANK5];
    bank_clk_gated[DFPS_B_D2_BANK4] = div0_clk[2] & en_q[DFPS_B_D2_BANK4];
    bank_clk_gated[DFPS_B_D1_BANK2] = div0_clk[1] & en_q[DFPS_B_D1_BANK2];
    bank_clk_gated[DFPS_B_D1_BANK1] = div0_clk[1] & en_q[DFPS_B_D1_BANK1];
    bank_clk_gated[DFPS_B_D1_BANK0] = div0_clk[1] & en_q[DFPS_B_D1_BANK0];
    bank_clk_gated[DFPS_B_D0_BANK1] = div0_clk[0] & en_q[DFPS_B_D0_BANK1];
    bank_clk_gated[DFPS_B_D0_BANK0] = div0_clk[0] & en_q[DFPS_B_D0_BANK0];
  end

  ////////////////////////////////////////////////////////////////////////
  // lock status and loss detection
  logic lock_q;
  logic lock_fall;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= det.locked;
    end
  end
  assign lock_fall = lock_q && !det.locked;

  logic [3:0] cnt_q;
  logic over_thr;
  dfps_lol_counter u_cnt (
    .clock(clock),
    .rstn(rstn),
    .inc(lock_fall),
    .load(req.wr && req.idx == DFPS_IDX_LOL_CNT),
    .load_val(req.wdata[3:0]),
    .count_q(cnt_q)
  );
  assign over_thr = cnt_q > lol_cnt_thresh;

  ////////////////////////////////////////////////////////////////////////
  // sticky event flags
  logic [3:0] evt_set;
  logic [3:0] evt_hold;
  logic [3:0] evt_q;
  logic wr_evt;
  assign wr_evt = req.wr && req.idx == DFPS_IDX_EVENT;
  always_comb begin
    evt_set = DFPS_EVT_RST;
    evt_hold = DFPS_EVT_RST;
    evt_set[DFPS_E_RAIL_HIGH] = det.rail_high;
    evt_set[DFPS_E_RAIL_LOW] = det.rail_low;
    evt_set[DFPS_E_LOL_LMT] = over_thr;
    evt_hold[DFPS_E_LOL_LMT] = over_thr;
    evt_set[DFPS_E_LOL] = lock_fall;
  end

  generate
    for (k = 0; k < 4; k++) begin : g_evt
      dfps_sticky u_flag (
        .clock(clock),
        .rstn(rstn),
        .set(evt_set[k]),
        .clr(wr_evt && req.wdata[k]),
        .hold(evt_hold[k]),
        .flag_q(evt_q[k])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read data, registered: answer one cycle after the index is shown
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      case (req.idx)
        DFPS_IDX_CLK_EN: rdata <= en_q;
        DFPS_IDX_STATUS: rdata <= {7'h00, lock_q};
        DFPS_IDX_EVENT: rdata <= {4'h0, evt_q};
        DFPS_IDX_LOL_CNT: rdata <= {4'h0, cnt_q};
        default: rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_enable_reset: assert property (@(posedge clock)
    $rose(rstn) |-> en_q == DFPS_CLK_EN_RST)
    else $error("enable byte not all ones after reset");
  a_write_lands: assert property (@(posedge clock) disable iff (!rstn)
    wr_en && auto_take == 3'b000 |=> en_q == $past(req.wdata))
    else $error("enable write lost");
  a_low_gate: assert property (@(posedge clock) disable iff (!rstn)
    !en_q[DFPS_B_D1_BANK0] |-> !bank_clk_gated[DFPS_B_D1_BANK0])
    else $error("divider 1 passes to bank 0 while disabled");
  a_auto_owns: assert property (@(posedge clock) disable iff (!rstn)
    auto_take[0] |=> en_q[DFPS_B_D2_BANK4] == $past(bank_auto[0].mux_sel))
    else $error("bank 4 enable not following mux");
  a_lock_status: assert property (@(posedge clock) disable iff (!rstn)
    det.locked |=> lock_q)
    else $error("lock status missed");
  a_rail_sticky: assert property (@(posedge clock) disable iff (!rstn)
    evt_q[DFPS_E_RAIL_HIGH] && !(wr_evt && req.wdata[DFPS_E_RAIL_HIGH])
    |=> evt_q[DFPS_E_RAIL_HIGH])
    else $error("rail high flag dropped");
  a_rail_low_set: assert property (@(posedge clock) disable iff (!rstn)
    det.rail_low |=> evt_q[DFPS_E_RAIL_LOW])
    else $error("rail low not caught");
  a_limit_hold: assert property (@(posedge clock) disable iff (!rstn)
    over_thr |=> evt_q[DFPS_E_LOL_LMT])
    else $error("limit flag cleared while over threshold");
  // one cycle only: software may legally clear the flag right after it sets
  a_lol_set: assert property (@(posedge clock) disable iff (!rstn)
    lock_fall |=> evt_q[DFPS_E_LOL])
    else $error("loss of lock not caught");
  a_count_sat: assert property (@(posedge clock) disable iff (!rstn)
    cnt_q == DFPS_CNT_MAX && !(req.wr && req.idx == DFPS_IDX_LOL_CNT)
    |=> cnt_q == DFPS_CNT_MAX)
    else $error("counter wrapped");

  // rail high is caught the cycle after the detector reports it
  a_rail_high_set: assert property (@(posedge clock) disable iff (!rstn)
    det.rail_high |=> evt_q[DFPS_E_RAIL_HIGH])
    else $error("rail high not caught");

  // once the count is back under the threshold a clear must take
  a_limit_clear: assert property (@(posedge clock) disable iff (!rstn)
    !over_thr && wr_evt && req.wdata[DFPS_E_LOL_LMT]
    |=> !evt_q[DFPS_E_LOL_LMT])
    else $error("limit flag not cleared");

  // an unloaded lock loss below the ceiling adds exactly one
  a_count_step: assert property (@(posedge clock) disable iff (!rstn)
    lock_fall && !(req.wr && req.idx == DFPS_IDX_LOL_CNT) &&
    cnt_q != DFPS_CNT_MAX
    |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("counter step wrong");

  // a rail high event coinciding with its clear must survive
  a_set_wins: assert property (@(posedge clock) disable iff (!rstn)
    det.rail_high && wr_evt && req.wdata[DFPS_E_RAIL_HIGH]
    |=> evt_q[DFPS_E_RAIL_HIGH])
    else $error("event lost to clear");

  // status reads show only the lock bit, upper bits zero
  a_status_read: assert property (@(posedge clock) disable iff (!rstn)
    req.idx == DFPS_IDX_STATUS |=> rdata == {7'h00, $past(lock_q)})
    else $error("status read wrong");

  // a clear of the loss flag with no new loss takes effect
  a_lol_clear: assert property (@(posedge clock) disable iff (!rstn)
    !lock_fall && wr_evt && req.wdata[DFPS_E_LOL]
    |=> !evt_q[DFPS_E_LOL])
    else $error("loss flag not cleared");

  c_set_wins: cover property (@(posedge clock) disable iff (!rstn)
    det.rail_high && wr_evt && req.wdata[DFPS_E_RAIL_HIGH]);
  c_saturate: cover property (@(posedge clock) disable iff (!rstn)
    cnt_q == DFPS_CNT_MAX && lock_fall);
  c_lock_lost: cover property (@(posedge clock) disable iff (!rstn)
    lock_fall);
  c_auto_mode: cover property (@(posedge clock) disable iff (!rstn)
    auto_take[2] && wr_en);
  c_limit: cover property (@(posedge clock) disable iff (!rstn)
    over_thr ##1 !over_thr);
endmodule

// ===== verification/dfps_top_bench.sv
`timescale 1ns/1ns
module dfps_top_bench;
  import dfps_pkg::*;
  logic clock;
  logic rstn;
  dfps_req_t req;
  logic [7:0] rdata;
  dfps_det_t det;
  logic [3:0] lol_cnt_thresh;
  dfps_bank_t [2:0] bank_auto;
  logic [2:0] div0_clk;
  logic [7:0] bank_clk_gated;
  logic [7:0] clk_en;
  logic [7:0] d_q;
  logic [7:0] exp_d;
  int miscompares = 0;
  int compares = 0;

  dfps_top u_dfps_top (
    .clock(clock),
    .rstn(rstn),
    .req(req),
    .rdata(rdata),
    .det(det),
    .lol_cnt_thresh(lol_cnt_thresh),
    .bank_auto(bank_auto),
    .div0_clk(div0_clk),
    .bank_clk_gated(bank_clk_gated),
    .clk_en(clk_en)
  );

  ////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // inputs move 1 ns after the edge so the design samples settled values
  task automatic tick(int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // one-cycle write strobe, effect lands on the strobe's edge
  task automatic wr(logic [1:0] i, logic [7:0] d);
    req = '{wr: 1'b1, idx: i, wdata: d};
    tick();
    req.wr = 1'b0;
  endtask

  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // rdata is registered, so it is read one edge after idx is presented
  task automatic chk_reg(string nm, logic [1:0] i, logic [7:0] exp);
    req.idx = i;
    tick();
    chk(nm, exp, rdata);
  endtask

  // each divider clock fans out to its own group of enable bits
  function automatic logic [7:0] gate_exp(logic [7:0] en, logic [2:0] dc);
    return en & {{3{dc[2]}}, {3{dc[1]}}, {2{dc[0]}}};
  endfunction

  // one lock loss: lock, then drop, leaving time for the edge detector
  task automatic lose_lock();
    det.locked = 1'b1;
    tick(2);
    det.locked = 1'b0;
    tick(2);
  endtask

  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // a hang is cut well past the expected run of some 140 cycles
  initial begin
    #20000;
    miscompares++;
    test_done();
  end

  // main sequence
  initial begin
    req = '0;
    det = '0;
    lol_cnt_thresh = 4'hf;
    bank_auto = '0;
    div0_clk = 3'h0;
    rstn = 1'b0;
    void'($urandom(32'hc5fa));
    repeat (6) @(posedge clock);
    #1 rstn = 1'b1;
    chk("clk_en reset", 8'hff, clk_en);
    chk_reg("status reset", DFPS_IDX_STATUS, 8'h00);
    chk_reg("events reset", DFPS_IDX_EVENT, 8'h00);
    chk_reg("count reset", DFPS_IDX_LOL_CNT, 8'h00);
    $display("test reset done");
    // random enables with random auto takeover of banks 4..6
    for (int t = 0; t < 40; t++) begin
      d_q = 8'($urandom);
      div0_clk = 3'($urandom);
      exp_d = d_q;
      for (int k = 0; k < 3; k++) begin
        bank_auto[k].auto_mode = 1'($urandom);
        bank_auto[k].src = 3'($urandom_range(1, 3));
        bank_auto[k].mux_sel = 1'($urandom);
        if (bank_auto[k].auto_mode && bank_auto[k].src == DFPS_AUTO_SRC)
          exp_d[5 + k] = bank_auto[k].mux_sel;
      end
      if (t == 0) d_q = 8'h00;
      if (t == 0) exp_d = 8'h00;
      if (t == 0) bank_auto = '0;
      wr(DFPS_IDX_CLK_EN, d_q);
      chk_reg("clk_en read", DFPS_IDX_CLK_EN, exp_d);
      chk("clk_en auto", exp_d, clk_en);
      chk("gated", gate_exp(exp_d, div0_clk), bank_clk_gated);
    end
    bank_auto = '0;
    $display("test enables done");
    // lock status, lock-loss flag and counter
    det.locked = 1'b1;
    tick(2);
    chk_reg("status locked", DFPS_IDX_STATUS, 8'h01);
    det.locked = 1'b0;
    tick(2);
    chk_reg("lol flag", DFPS_IDX_EVENT, 8'h01);
    chk_reg("count one", DFPS_IDX_LOL_CNT, 8'h01);
    wr(DFPS_IDX_EVENT, 8'h01);
    chk_reg("lol clear", DFPS_IDX_EVENT, 8'h00);
    // rail flags hold after the level drops
    det.rail_high = 1'b1;
    tick();
    det.rail_high = 1'b0;
    det.rail_low = 1'b1;
    tick();
    det.rail_low = 1'b0;
    tick(2);
    chk_reg("rail flags", DFPS_IDX_EVENT, 8'h0c);
    // set in the same cycle as its clear must win
    det.rail_high = 1'b1;
    wr(DFPS_IDX_EVENT, 8'h0c);
    det.rail_high = 1'b0;
    chk_reg("set wins", DFPS_IDX_EVENT, 8'h08);
    wr(DFPS_IDX_EVENT, 8'h08);
    chk_reg("rail clear", DFPS_IDX_EVENT, 8'h00);
    $display("test events done");
    // counter preset, saturation and threshold flag
    wr(DFPS_IDX_LOL_CNT, 8'h0e);
    repeat (3) lose_lock();
    chk_reg("count sat", DFPS_IDX_LOL_CNT, 8'h0f);
    lol_cnt_thresh = 4'h3;
    tick();
    chk_reg("lmt set", DFPS_IDX_EVENT, 8'h03);
    wr(DFPS_IDX_EVENT, 8'h03);
    chk_reg("lmt held", DFPS_IDX_EVENT, 8'h02);
    wr(DFPS_IDX_LOL_CNT, 8'h00);
    chk_reg("count load", DFPS_IDX_LOL_CNT, 8'h00);
    wr(DFPS_IDX_EVENT, 8'h02);
    chk_reg("lmt clear", DFPS_IDX_EVENT, 8'h00);
    // count equal to the threshold is not over it
    wr(DFPS_IDX_LOL_CNT, 8'h03);
    tick();
    chk_reg("lmt at equal", DFPS_IDX_EVENT, 8'h00);
    wr(DFPS_IDX_LOL_CNT, 8'h00);
    wr(DFPS_IDX_STATUS, 8'hff);
    chk_reg("status ro", DFPS_IDX_STATUS, 8'h00);
    $display("test counter done");
    // second reset in mid-run
    wr(DFPS_IDX_CLK_EN, 8'h00);
    rstn = 1'b0;
    tick();
    rstn = 1'b1;
    chk("clk_en rereset", 8'hff, clk_en);
    chk_reg("count rereset", DFPS_IDX_LOL_CNT, 8'h00);
    $display("test rereset done");
    test_done();
  end
endmodule
